//--- rtl/external_bus_port_sequencer.sv
/*
  external memory port sequencer: address, data, strobes, space selects,
  wait states, strobe/wait handshake, bus request/grant and rmw sequences.
  assumes the core presents one request at a time and holds it until ready.
*/
`timescale 1ns/10ps
// Operation
// - bus cycle is two T phases
// - insert 0 to 15 programmed waits
// - internal access: strobes off, address/xy held
// - internal access drops selects; no toggle between
// - float bus before or with grant
// - grant 2-4 cycles idle, after access otherwise
// - stop: no new grant, keep existing grant; a FLOAT already entered before stop still grants
// - wait mode keeps request/grant logic alive
// - write strobe half/one cycle after address
// - write width one cycle or WS*cyc+tcl
// - bus strobe on after fall, off after rise
// - rmw: address held, bus strobe re-asserted
module external_bus_port_sequencer (
  // clock and reset
  input  wire logic                                i_core_clk,
  input  wire logic                                i_arst_n,
  // core request side
  input  wire logic                                i_req_valid,
  input  ext_bus_pkg::bus_req_s                    i_req,
  output logic                                     o_req_ready,
  output logic                                     o_ack,
  output logic [23:0]                              o_rdata,
  // configuration and power modes
  input  ext_bus_pkg::bus_control_config_s         i_bus_control_config,
  input  wire logic                                i_stop_mode,
  input  wire logic                                i_wait_mode,
  // memory pins
  output logic [15:0]                              o_addr,
  output logic                                     o_addr_oe,
  output logic [23:0]                              o_data,
  output logic                                     o_data_oe,
  input  wire logic [23:0]                         i_data,
  output logic                                     o_rd_n,
  output logic                                     o_wr_n,
  output logic                                     o_xy,
  output logic                                     o_program_space_select_n,
  output logic                                     o_data_space_select_n,
  output logic                                     o_bus_strobe_n,
  output logic                                     o_ctrl_oe,
  input  wire logic                                i_wait_input_n,
  // arbitration pins
  input  wire logic                                i_bus_request_n,
  output logic                                     o_bus_grant_n
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0]  arb_s;
  logic [23:0] data_s;
  logic        breq_n_s;
  logic        wt_n_s;

  pin_sync #(.W(2)) u_arb_sync (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_async    ({i_bus_request_n, i_wait_input_n}),
    .i_rst_val  (2'h3),
    .o_sync     (arb_s)
  );

  pin_sync #(.W(24)) u_data_sync (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_async    (i_data),
    .i_rst_val  (24'hffffff),
    .o_sync     (data_s)
  );

  assign breq_n_s = arb_s[1];
  assign wt_n_s   = arb_s[0];

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_FLOAT, ST_GRANTED} seq_state_e;

  seq_state_e  state_r, state_nxt;
  logic        phase_r, phase_nxt;
  logic [5:0]  idx_r, idx_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic        hs_r, hs_nxt;
  logic        write_r, write_nxt;
  logic        rmw_r, rmw_nxt;
  logic [2:0]  gcnt_r, gcnt_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [23:0] data_r, data_nxt;
  logic [23:0] rdata_r, rdata_nxt;
  logic        xy_r, xy_nxt;
  logic        ps_n_r, ps_n_nxt;
  logic        ds_n_r, ds_n_nxt;
  logic        ack_r, ack_nxt;
  logic        grant_n_r, grant_n_nxt;
  logic [5:0]  idx_end;
  logic [5:0]  wr_start;
  logic        take_ext;
  logic        take_int;

  // handshake forces at least two waits; the far agent relies on it
  logic [3:0] ws_eff;
  assign ws_eff = (i_bus_control_config.handshake_en &&
                   i_bus_control_config.wait_state_count < ext_bus_pkg::HS_MIN_WS) ?
                  ext_bus_pkg::HS_MIN_WS : i_bus_control_config.wait_state_count;

  // access length in phases: strobe ends on the rising phase at idx_end
  assign idx_end  = (ws_r == 4'h0) ? ext_bus_pkg::IDX_TAIL :
                    {1'b0, ws_r, 1'b0} + ext_bus_pkg::IDX_TAIL;
  assign wr_start = (ws_r == 4'h0) ? ext_bus_pkg::WR_START_WS0 :
                    ext_bus_pkg::WR_START_WSN;

  // new external accesses only launch so that idx 0 lands on a low phase
  assign take_ext = (state_r == ST_IDLE) && breq_n_s && i_req_valid && i_req.ext &&
                    (phase_r == ext_bus_pkg::PH_HIGH);
  assign take_int = (state_r == ST_IDLE) && breq_n_s && i_req_valid && !i_req.ext;
  assign o_req_ready = take_ext || take_int;

  always_comb begin
    state_nxt   = state_r;
    phase_nxt   = ~phase_r;
    idx_nxt     = idx_r;
    ws_nxt      = ws_r;
    hs_nxt      = hs_r;
    write_nxt   = write_r;
    rmw_nxt     = rmw_r;
    gcnt_nxt    = gcnt_r;
    addr_nxt    = addr_r;
    data_nxt    = data_r;
    rdata_nxt   = rdata_r;
    xy_nxt      = xy_r;
    ps_n_nxt    = ps_n_r;
    ds_n_nxt    = ds_n_r;
    ack_nxt     = 1'b0;
    grant_n_nxt = grant_n_r;
    case (state_r)
      ST_IDLE: begin
        // wait mode does not gate arbitration, stop mode does
        if (!breq_n_s && !i_stop_mode) begin
          state_nxt = ST_FLOAT;
          gcnt_nxt  = 3'h1;
        end else if (take_int) begin
          // addr and xy keep their last value to save pin power
          ps_n_nxt = 1'b1;
          ds_n_nxt = 1'b1;
          ack_nxt  = 1'b1;
        end else if (take_ext) begin
          state_nxt = ST_ACCESS;
          idx_nxt   = 6'h00;
          ws_nxt    = ws_eff;
          hs_nxt    = i_bus_control_config.handshake_en;
          write_nxt = i_req.write && !i_req.rmw;
          rmw_nxt   = i_req.rmw;
          addr_nxt  = i_req.addr;
          data_nxt  = i_req.wdata;
          xy_nxt    = (i_req.space == ext_bus_pkg::SPACE_Y);
          ps_n_nxt  = (i_req.space != ext_bus_pkg::SPACE_P);
          ds_n_nxt  = (i_req.space == ext_bus_pkg::SPACE_P);
        end
      end
      ST_ACCESS: begin
        if (idx_r == idx_end) begin
          if (!write_r) begin
            rdata_nxt = data_s;
          end
          if (rmw_r) begin
            // second half reuses the address; strobe is off for this phase
            idx_nxt   = 6'h00;
            write_nxt = 1'b1;
            rmw_nxt   = 1'b0;
          end else begin
            state_nxt = ST_IDLE;
            ack_nxt   = 1'b1;
          end
        // stretch in whole bus cycles so the strobe edges keep their clock phase
        end else if (!(hs_r && idx_r == idx_end - 6'h01 &&
                       (!wt_n_s || phase_r != ext_bus_pkg::PH_LOW))) begin
          idx_nxt = idx_r + 6'h01;
        end
      end
      ST_FLOAT: begin
        // grant is deferred past any access because FLOAT is entered from IDLE
        if (breq_n_s) begin
          state_nxt = ST_IDLE;
        end else if (gcnt_r == ext_bus_pkg::GRANT_CLKS) begin
          state_nxt   = ST_GRANTED;
          grant_n_nxt = 1'b0;
        end else begin
          gcnt_nxt = gcnt_r + 3'h1;
        end
      end
      ST_GRANTED: begin
        if (breq_n_s && !i_stop_mode) begin
          state_nxt   = ST_IDLE;
          grant_n_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r   <= ST_IDLE;
      phase_r   <= ext_bus_pkg::PH_HIGH;
      idx_r     <= 6'h00;
      ws_r      <= 4'h0;
      hs_r      <= 1'b0;
      write_r   <= 1'b0;
      rmw_r     <= 1'b0;
      gcnt_r    <= 3'h0;
      addr_r    <= ext_bus_pkg::ADDR_RST;
      data_r    <= ext_bus_pkg::DATA_RST;
      rdata_r   <= ext_bus_pkg::DATA_RST;
      xy_r      <= ext_bus_pkg::XY_RST;
      ps_n_r    <= 1'b1;
      ds_n_r    <= 1'b1;
      ack_r     <= 1'b0;
      grant_n_r <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      phase_r   <= phase_nxt;
      idx_r     <= idx_nxt;
      ws_r      <= ws_nxt;
      hs_r      <= hs_nxt;
      write_r   <= write_nxt;
      rmw_r     <= rmw_nxt;
      gcnt_r    <= gcnt_nxt;
      addr_r    <= addr_nxt;
      data_r    <= data_nxt;
      rdata_r   <= rdata_nxt;
      xy_r      <= xy_nxt;
      ps_n_r    <= ps_n_nxt;
      ds_n_r    <= ds_n_nxt;
      ack_r     <= ack_nxt;
      grant_n_r <= grant_n_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  logic in_acc;
  logic drive;
  assign in_acc = (state_r == ST_ACCESS) && (idx_r != idx_end);
  assign drive  = (state_r == ST_IDLE) || (state_r == ST_ACCESS);

  assign o_bus_strobe_n = !in_acc;
  assign o_rd_n         = !(in_acc && !write_r && idx_r >= ext_bus_pkg::RD_START);
  assign o_wr_n         = !(in_acc && write_r && idx_r >= wr_start);
  assign o_addr         = addr_r;
  assign o_addr_oe      = drive;
  assign o_data         = data_r;
  assign o_data_oe      = (state_r == ST_ACCESS) && write_r;
  assign o_xy           = xy_r;
  assign o_program_space_select_n = ps_n_r;
  assign o_data_space_select_n    = ds_n_r;
  assign o_ctrl_oe      = drive;
  assign o_bus_grant_n  = grant_n_r;
  assign o_ack          = ack_r;
  assign o_rdata        = rdata_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_strobe_drop;
    $rose(o_bus_strobe_n) ##1 $fell(o_bus_strobe_n);
  endsequence

  sequence s_wr_ws0;
    !o_wr_n [*2] ##1 o_wr_n;
  endsequence

  chk_grant_float: assert property (!o_bus_grant_n |-> !o_addr_oe && !o_ctrl_oe && !o_data_oe)
    else $error("grant asserted while bus driven");
  chk_grant_delay: assert property ($fell(o_bus_grant_n) |->
      $past(!breq_n_s, 1) && $past(!breq_n_s, 4))
    else $error("grant came too early after request");
  chk_stop_nogrant: assert property (o_bus_grant_n && i_stop_mode && state_r != ST_FLOAT
      |=> o_bus_grant_n)
    else $error("grant issued during stop");
  chk_stop_keep: assert property (!o_bus_grant_n && i_stop_mode |=> !o_bus_grant_n)
    else $error("grant dropped during stop");
  chk_int_selects: assert property (take_int |=> o_program_space_select_n &&
      o_data_space_select_n && $stable(o_addr) && $stable(o_xy) && o_rd_n && o_wr_n)
    else $error("internal access disturbed the bus");
  chk_sel_stable: assert property (state_r == ST_ACCESS && $past(state_r) == ST_ACCESS |->
      $stable(o_program_space_select_n) && $stable(o_data_space_select_n))
    else $error("space select toggled during access");
  chk_wr_width0: assert property ($fell(o_wr_n) && ws_r == 4'h0 |-> s_wr_ws0)
    else $error("zero wait write width wrong");
  chk_wr_delay: assert property ($fell(o_bus_strobe_n) && write_r |->
      ##(1) (ws_r == 4'h0 ? !o_wr_n : o_wr_n))
    else $error("write strobe placement wrong");
  chk_strobe_phase: assert property ($fell(o_bus_strobe_n) |-> phase_r == ext_bus_pkg::PH_LOW)
    else $error("bus strobe asserted on wrong phase");
  chk_rmw_addr: assert property ($rose(o_bus_strobe_n) && rmw_r |->
      s_strobe_drop ##0 $stable(o_addr))
    else $error("rmw address or strobe sequence wrong");
  chk_ws_min_hs: assert property (state_r == ST_ACCESS && hs_r |-> ws_r >= ext_bus_pkg::HS_MIN_WS)
    else $error("handshake access below two waits");
  chk_wait_len: assert property ($fell(o_bus_strobe_n) && !hs_r && ws_r == 4'h1 |->
      !o_bus_strobe_n [*5] ##1 o_bus_strobe_n)
    else $error("one wait access length wrong");

endmodule // external_bus_port_sequencer

//--- rtl/ext_bus_pkg.sv
/*
  shared constants and carrier types for the external bus port sequencer.
  assumes one core clock per T phase, so one bus cycle is two core clocks.
*/
package ext_bus_pkg;

  // ----------------------------------------------------------------
  // phases and cycle arithmetic
  // ----------------------------------------------------------------
  localparam logic       PH_HIGH           = 1'b0;
  localparam logic       PH_LOW            = 1'b1;
  localparam int         PHASES_PER_CYC    = 2;
  localparam int         GRANT_MIN_BUS_CYC = 2;
  localparam logic [2:0] GRANT_CLKS        = 3'(GRANT_MIN_BUS_CYC * PHASES_PER_CYC);
  localparam logic [3:0] HS_MIN_WS         = 4'h2;
  localparam logic [5:0] IDX_TAIL          = 6'h03;
  localparam logic [5:0] WR_START_WS0      = 6'h01;
  localparam logic [5:0] WR_START_WSN      = 6'h02;
  localparam logic [5:0] RD_START          = 6'h01;

  // ----------------------------------------------------------------
  // spaces and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  SPACE_P   = 2'h0;
  localparam logic [1:0]  SPACE_X   = 2'h1;
  localparam logic [1:0]  SPACE_Y   = 2'h2;
  localparam logic [15:0] ADDR_RST  = 16'h0000;
  localparam logic [23:0] DATA_RST  = 24'h000000;
  localparam logic        XY_RST    = 1'b0;

  typedef struct packed {
    logic        ext;
    logic [1:0]  space;
    logic        write;
    logic        rmw;
    logic [15:0] addr;
    logic [23:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic [3:0] wait_state_count;
    logic       handshake_en;
  } bus_control_config_s;

endpackage

//--- rtl/pin_sync.sv
/*
  two-flop synchroniser for pins entering the core clock domain.
  assumes each bit is independent; multi-bit buses must be quiet when read.
*/
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_arst_n,
  // data
  input  wire logic [W-1:0] i_async,
  input  wire logic [W-1:0] i_rst_val,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // reset to all ones: every synced pin here idles high
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r & (i_rst_val | ~i_rst_val);

endmodule // pin_sync

//--- verification/ext_mem_model.sv
/*
  external memory and alternate bus master facing the sequencer pins.
  assumes the bench commands the wait stretch and the bus request.
*/
`timescale 1ns/10ps
module ext_mem_model (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  // memory pins
  input  wire logic [15:0] i_addr,
  input  wire logic [23:0] i_wdata,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic        i_bus_strobe_n,
  output logic      [23:0] o_rdata,
  output logic             o_wait_input_n,
  output logic             o_bus_request_n,
  // bench commands
  input  wire logic [3:0]  i_hold_clks,
  input  wire logic        i_want_bus
);
  logic [23:0] mem [256];
  logic [23:0] junk_r;
  logic [3:0]  hold_r;
  logic        bs_d_r;

  // released data lines wander so a stale word never passes as valid
  assign o_rdata         = i_rd_n ? junk_r : mem[i_addr[7:0]];
  assign o_wait_input_n  = (hold_r == 4'h0);
  assign o_bus_request_n = !i_want_bus;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      junk_r <= 24'h5a5a5a;
      hold_r <= 4'h0;
      bs_d_r <= 1'b1;
    end else begin
      junk_r <= ~junk_r;
      bs_d_r <= i_bus_strobe_n;
      // fresh stretch per strobe, so each rmw half asks on its own
      if (bs_d_r && !i_bus_strobe_n) begin
        hold_r <= i_hold_clks;
      end else if (hold_r != 4'h0) begin
        hold_r <= hold_r - 4'h1;
      end
      if (!i_wr_n) begin
        mem[i_addr[7:0]] <= i_wdata;
      end
    end
  end
endmodule // ext_mem_model

//--- verification/external_bus_port_sequencer_tb_top.sv
/*
  self-checking bench for the external bus port sequencer.
  assumes ext_mem_model stands on the memory and arbitration pins.
*/
`timescale 1ns/10ps
module external_bus_port_sequencer_tb_top;
  logic                             clk;
  logic                             arst_n;
  logic                             req_valid;
  ext_bus_pkg::bus_req_s            req;
  ext_bus_pkg::bus_control_config_s cfg;
  logic                             stop_m;
  logic                             wait_m;
  logic                             want;
  logic [3:0]                       hold;
  logic                             ready;
  logic                             ack;
  logic [23:0]                      rdata;
  logic [15:0]                      addr;
  logic                             addr_oe;
  logic [23:0]                      wdata;
  logic                             data_oe;
  logic [23:0]                      pin_data;
  logic                             rd_n;
  logic                             wr_n;
  logic                             xy;
  logic                             ps_n;
  logic                             ds_n;
  logic                             bs_n;
  logic                             ctrl_oe;
  logic                             wait_n;
  logic                             breq_n;
  logic                             gnt_n;
  int n_fail, check_count, n_clk, n_wr, n_lead, n_bsf, n_achg, n_strb, n_gnt, ps_rise;

  external_bus_port_sequencer external_bus_port_sequencer_inst (
    .i_core_clk(clk), .i_arst_n(arst_n), .i_req_valid(req_valid), .i_req(req),
    .o_req_ready(ready), .o_ack(ack), .o_rdata(rdata), .i_bus_control_config(cfg),
    .i_stop_mode(stop_m), .i_wait_mode(wait_m), .o_addr(addr), .o_addr_oe(addr_oe),
    .o_data(wdata), .o_data_oe(data_oe), .i_data(pin_data), .o_rd_n(rd_n), .o_wr_n(wr_n),
    .o_xy(xy), .o_program_space_select_n(ps_n), .o_data_space_select_n(ds_n),
    .o_bus_strobe_n(bs_n), .o_ctrl_oe(ctrl_oe), .i_wait_input_n(wait_n),
    .i_bus_request_n(breq_n), .o_bus_grant_n(gnt_n));

  ext_mem_model ext_mem_model_inst (
    .i_core_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .i_bus_strobe_n(bs_n), .o_rdata(pin_data), .o_wait_input_n(wait_n),
    .o_bus_request_n(breq_n), .i_hold_clks(hold), .i_want_bus(want));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge ps_n) ps_rise++;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic setcfg(input int ws, input logic hs, input logic [3:0] hd);
    @(posedge clk);
    #1 cfg = '{wait_state_count: 4'(ws), handshake_en: hs};
    hold = hd;
  endtask

  task automatic access(input logic ext, input logic [1:0] sp, input logic wr,
                        input logic rmw, input logic [15:0] a, input logic [23:0] d);
    int i;
    logic bs_prev;
    logic seen_wr;
    logic [15:0] a_ref;
    {n_clk, n_wr, n_lead, n_bsf, n_achg, n_strb, n_gnt, i} = '0;
    bs_prev = 1'b1;
    seen_wr = 1'b0;
    a_ref = addr;
    @(posedge clk);
    #1 req = '{ext: ext, space: sp, write: wr, rmw: rmw, addr: a, wdata: d};
    req_valid = 1'b1;
    do begin
      @(negedge clk);
      i++;
    end while (ready !== 1'b1 && i < 200);
    @(posedge clk);
    #1 req_valid = 1'b0;
    while (ack !== 1'b1 && n_clk < 300) begin
      @(negedge clk);
      n_clk++;
      if (bs_prev && !bs_n && n_bsf++ == 0) a_ref = addr;
      bs_prev = bs_n;
      if ((!ext || !bs_n) && addr !== a_ref) n_achg++;
      if (!rd_n || !wr_n) n_strb++;
      if (!gnt_n) n_gnt++;
      if (!wr_n) seen_wr = 1'b1;
      if (!wr_n) n_wr++;
      else if (!seen_wr && !bs_n) n_lead++;
    end
    if (i >= 200 || n_clk >= 300) n_fail++;
  endtask

  task automatic grab(output int n);
    n = 0;
    @(posedge clk);
    #1 want = 1'b1;
    while (gnt_n !== 1'b0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (n >= 60) n_fail++;
  endtask

  task automatic drop();
    @(posedge clk);
    #1 want = 1'b0;
    repeat (12) @(negedge clk);
    check("grant_release", 1, gnt_n);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_sweep();
    int wsl[4] = '{0, 1, 2, 15};
    foreach (wsl[k]) begin
      setcfg(wsl[k], 1'b0, 4'h0);
      access(1'b1, ext_bus_pkg::SPACE_X, 1'b1, 1'b0, 16'(16 + wsl[k]), 24'h3c5a96 ^ 24'(k));
      check("write_clks", 2 * wsl[k] + 5, n_clk);
      check("wr_width", wsl[k] == 0 ? 2 : 2 * wsl[k] + 1, n_wr);
      check("wr_lead", wsl[k] == 0 ? 1 : 2, n_lead);
      check("strobe_count", 1, n_bsf);
      access(1'b1, ext_bus_pkg::SPACE_X, 1'b0, 1'b0, 16'(16 + wsl[k]), 24'h0);
      check("read_clks", 2 * wsl[k] + 5, n_clk);
      check("read_data", 24'h3c5a96 ^ 24'(k), rdata);
    end
  endtask

  task automatic t_space();
    int r;
    setcfg(0, 1'b0, 4'h0);
    r = ps_rise;
    access(1'b1, ext_bus_pkg::SPACE_P, 1'b1, 1'b0, 16'h0020, 24'h000111);
    access(1'b1, ext_bus_pkg::SPACE_P, 1'b0, 1'b0, 16'h0020, 24'h0);
    check("p_select_toggles", 0, ps_rise - r);
    check("p_read", 24'h000111, rdata);
    access(1'b1, ext_bus_pkg::SPACE_Y, 1'b1, 1'b0, 16'h0031, 24'h0abcde);
    access(1'b0, ext_bus_pkg::SPACE_X, 1'b0, 1'b0, 16'h0077, 24'h0);
    check("int_strobes", 0, n_strb);
    check("int_addr", 16'h0031, addr);
    check("int_xy", 1, xy);
    check("int_selects", 2'b11, {ps_n, ds_n});
  endtask

  task automatic t_rmw(input logic hs, input logic [3:0] hd);
    setcfg(1, hs, hd);
    access(1'b1, ext_bus_pkg::SPACE_X, 1'b1, 1'b0, 16'h0040, 24'h123456);
    access(1'b1, ext_bus_pkg::SPACE_X, 1'b1, 1'b1, 16'h0040, 24'h654321);
    check("rmw_old", 24'h123456, rdata);
    check("rmw_strobes", 2, n_bsf);
    check("rmw_addr_moves", 0, n_achg);
    access(1'b1, ext_bus_pkg::SPACE_X, 1'b0, 1'b0, 16'h0040, 24'h0);
    check("rmw_new", 24'h654321, rdata);
  endtask

  task automatic t_hs();
    setcfg(0, 1'b1, 4'h0);
    access(1'b1, ext_bus_pkg::SPACE_X, 1'b0, 1'b0, 16'h0040, 24'h0);
    check("hs_min_clks", 9, n_clk);
    setcfg(0, 1'b1, 4'hc);
    access(1'b1, ext_bus_pkg::SPACE_X, 1'b0, 1'b0, 16'h0040, 24'h0);
    check("hs_stretched", 1, n_clk > 9);
    check("hs_data", 24'h654321, rdata);
  endtask

  task automatic t_arb();
    int n;
    grab(n);
    check("grant_delay", 1, n >= 4 && n <= 9);
    check("float_at_grant", 0, {addr_oe, data_oe, ctrl_oe});
    drop();
    setcfg(15, 1'b0, 4'h0);
    fork
      access(1'b1, ext_bus_pkg::SPACE_X, 1'b1, 1'b0, 16'h0050, 24'h000050);
      begin
        repeat (6) @(posedge clk);
        #1 want = 1'b1;
      end
    join
    check("grant_in_access", 0, n_gnt);
    grab(n);
    check("grant_after_access", 1, n <= 8);
    drop();
    @(posedge clk);
    #1 stop_m = 1'b1;
    want = 1'b1;
    repeat (40) @(negedge clk);
    check("stop_no_grant", 1, gnt_n);
    @(posedge clk);
    #1 stop_m = 1'b0;
    grab(n);
    @(posedge clk);
    #1 stop_m = 1'b1;
    want = 1'b0;
    repeat (20) @(negedge clk);
    check("stop_keeps_grant", 0, {gnt_n, addr_oe, ctrl_oe});
    @(posedge clk);
    #1 stop_m = 1'b0;
    wait_m = 1'b1;
    drop();
    grab(n);
    check("wait_mode_grant", 1, n <= 9);
    drop();
  endtask

  initial begin
    {arst_n, req_valid, stop_m, wait_m, want} = '0;
    req = '0;
    cfg = '0;
    hold = 4'h0;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    check("idle_pins", 4'hf, {rd_n, wr_n, bs_n, gnt_n});
    t_sweep();
    t_space();
    t_rmw(1'b0, 4'h0);
    t_rmw(1'b1, 4'h8);
    t_hs();
    t_arb();
    complete_run();
  end

  // hang guard at 20000 cycles, far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
endmodule // external_bus_port_sequencer_tb_top
